// [inc/acc_pkg.sv]
// constants, register layouts and carrier types of the acquisition chain control
// assumes a 200 MHz system clock and a classic wishbone register bus
`default_nettype none
package acc_pkg;

   // ***********************************************
   // register map (word index, byte address = 4 x index)
   // ***********************************************
   localparam logic [2:0] REG_CFG0 = 3'h0;
   localparam logic [2:0] REG_CFG1 = 3'h1;
   localparam logic [2:0] REG_CFG2 = 3'h2;
   localparam logic [2:0] REG_CFG3 = 3'h3;
   localparam logic [2:0] REG_CFG4 = 3'h4;
   localparam logic [2:0] REG_CFG5 = 3'h5;
   localparam int NUM_REGS = 6;

   // ***********************************************
   // reset and restore values, writable masks
   // ***********************************************
   localparam logic [7:0] CFG0_DEF = 8'h28;
   localparam logic [7:0] CFG1_DEF = 8'hF0;
   localparam logic [7:0] CFG2_DEF = 8'hC0;
   localparam logic [7:0] CFG3_DEF = 8'h00;
   localparam logic [7:0] CFG4_DEF = 8'h00;
   localparam logic [7:0] CFG5_DEF = 8'h00;
   localparam logic [7:0] CFG0_WMASK = 8'h7E;
   localparam logic [7:0] CFG4_WMASK = 8'h7F;
   localparam logic [7:0] CFG5_WMASK = 8'h3F;

   // ***********************************************
   // timing
   // ***********************************************
   localparam int CLK_PERIOD_NS = 5;
   localparam int FS_MAX_PERIOD_NS = 2000;
   localparam logic [11:0] FS_BASE_CYC = 12'(FS_MAX_PERIOD_NS / CLK_PERIOD_NS);
   localparam logic [1:0] FS_SEL_MAX = 2'h3;
   localparam logic [10:0] OSR_BASE = 11'h008;
   localparam logic [3:0] NEL_ONE = 4'h1;

   // ***********************************************
   // register layouts
   // ***********************************************
   typedef struct packed {
      logic start;
      logic [1:0] conversion_count_sel;
      logic [2:0] oversample_ratio_sel;
      logic continuous;
      logic rsv;
   } acc_cfg0_s;

   typedef struct packed {
      logic [1:0] converter_bias_scale;
      logic [1:0] gain_stage_bias_scale;
      logic [3:0] enable;
   } acc_cfg1_s;

   typedef struct packed {
      logic [1:0] sample_freq_sel;
      logic [1:0] second_stage_gain;
      logic [3:0] second_stage_offset;
   } acc_cfg2_s;

   typedef struct packed {
      logic first_stage_gain;
      logic [6:0] third_stage_gain;
   } acc_cfg3_s;

   typedef struct packed {
      logic rsv;
      logic [6:0] third_stage_offset;
   } acc_cfg4_s;

   typedef struct packed {
      logic busy;
      logic restore;
      logic [4:0] input_sel;
      logic ref_select;
   } acc_cfg5_s;

   // ***********************************************
   // analog front end controls
   // ***********************************************
   typedef struct packed {
      logic [1:0] converter_bias_scale;
      logic [1:0] gain_stage_bias_scale;
      logic modulator_enable;
      logic [2:0] stage_enable;
      logic [2:0] stage_bypass;
      logic first_stage_gain;
      logic [1:0] second_stage_gain;
      logic [6:0] third_stage_gain;
      logic [3:0] second_stage_offset;
      logic [6:0] third_stage_offset;
      logic [2:0] pos_input;
      logic [2:0] neg_input;
      logic inputs_connected;
      logic ref_select;
   } acc_analog_s;

   typedef enum logic {ACC_IDLE, ACC_RUN} acc_state_e;

endpackage : acc_pkg
`default_nettype wire

// [rtl/acc_fs_divider.sv]
// over-sampling tick generator: one pulse every period clocks
// assumes restart is a one-cycle pulse from the sequencer
`timescale 1ns/10ps
`default_nettype none
module acc_fs_divider (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic restart,
   input wire logic [11:0] period,
   output logic tick
);

   logic [11:0] cnt;

   // ***********************************************
   // counter
   // ***********************************************
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 12'h000;
      end else if (restart || cnt >= period - 12'h001) begin
         cnt <= 12'h000;
      end else begin
         cnt <= cnt + 12'h001;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tick <= 1'b0;
      end else begin
         tick <= !restart && (cnt >= period - 12'h001);
      end
   end

endmodule : acc_fs_divider
`default_nettype wire

// [rtl/acc_mux_decode.sv]
// input multiplexer decode: mode, polarity and channel to terminal indices
// assumes input 0 is the common return in single-ended mode
`timescale 1ns/10ps
`default_nettype none
module acc_mux_decode (
   input wire logic [4:0] input_sel,
   output logic [2:0] pos_input,
   output logic [2:0] neg_input,
   output logic connected
);

   localparam logic [2:0] IN_ZERO = 3'h0;
   localparam logic [2:0] SE_LAST = 3'h5;
   localparam logic [1:0] DIFF_NC = 2'h3;

   logic [2:0] p;
   logic [2:0] n;

   // ***********************************************
   // decode
   // ***********************************************
   always_comb begin
      if (input_sel[4]) begin
         p = input_sel[2:0];
         n = IN_ZERO;
         connected = (input_sel[2:0] <= SE_LAST);
      end else begin
         p = {input_sel[1:0], 1'b1};
         n = {input_sel[1:0], 1'b0};
         connected = (input_sel[1:0] != DIFF_NC);
      end
      if (input_sel[3]) begin
         pos_input = n;
         neg_input = p;
      end else begin
         pos_input = p;
         neg_input = n;
      end
   end

endmodule : acc_mux_decode
`default_nettype wire

// [rtl/acc_chain_ctrl.sv]
// acquisition chain control: configuration registers and conversion sequencer
// assumes a classic wishbone master and a 200 MHz clock
`timescale 1ns/10ps
`default_nettype none
module acc_chain_ctrl (
   input wire logic clk,
   input wire logic nrst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [4:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output acc_pkg::acc_analog_s analog,
   output logic sample_tick,
   output logic chop_polarity,
   output logic conv_done,
   output logic busy
);

   // ***********************************************
   // reset release
   // ***********************************************
   logic rst_meta;
   logic rst_n_sync;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta <= 1'b0;
         rst_n_sync <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n_sync <= rst_meta;
      end
   end

   // ***********************************************
   // bus slave
   // ***********************************************
   logic [7:0] cfg [0:acc_pkg::NUM_REGS-1];
   logic [2:0] idx;
   logic wr_en;
   logic start_wr;
   logic cont_wr;
   logic restore_wr;
   logic [7:0] rd_byte;
   acc_pkg::acc_cfg0_s wr_c0;
   acc_pkg::acc_cfg5_s wr_c5;

   assign idx = wb_adr_i[4:2];
   assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
   assign wr_c0 = acc_pkg::acc_cfg0_s'(wb_dat_i[7:0]);
   assign wr_c5 = acc_pkg::acc_cfg5_s'(wb_dat_i[7:0]);
   assign start_wr = wr_en && idx == acc_pkg::REG_CFG0 && wr_c0.start;
   assign cont_wr = wr_en && idx == acc_pkg::REG_CFG0 && wr_c0.continuous;
   assign restore_wr = wr_en && idx == acc_pkg::REG_CFG5 && wr_c5.restore;

   always_ff @(posedge clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      end
   end

   always_comb begin
      rd_byte = 8'h00;
      unique case (idx)
         acc_pkg::REG_CFG0: rd_byte = cfg[acc_pkg::REG_CFG0] & acc_pkg::CFG0_WMASK;
         acc_pkg::REG_CFG1: rd_byte = cfg[acc_pkg::REG_CFG1];
         acc_pkg::REG_CFG2: rd_byte = cfg[acc_pkg::REG_CFG2];
         acc_pkg::REG_CFG3: rd_byte = cfg[acc_pkg::REG_CFG3];
         acc_pkg::REG_CFG4: rd_byte = cfg[acc_pkg::REG_CFG4] & acc_pkg::CFG4_WMASK;
         acc_pkg::REG_CFG5: rd_byte = {busy, 1'b0, cfg[acc_pkg::REG_CFG5][5:0]};
         default: rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i) begin
         wb_dat_o <= {24'h00_0000, rd_byte};
      end
   end

   // ***********************************************
   // configuration registers
   // ***********************************************
   always_ff @(posedge clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         cfg[acc_pkg::REG_CFG0] <= acc_pkg::CFG0_DEF;
         cfg[acc_pkg::REG_CFG1] <= acc_pkg::CFG1_DEF;
         cfg[acc_pkg::REG_CFG2] <= acc_pkg::CFG2_DEF;
         cfg[acc_pkg::REG_CFG3] <= acc_pkg::CFG3_DEF;
         cfg[acc_pkg::REG_CFG4] <= acc_pkg::CFG4_DEF;
         cfg[acc_pkg::REG_CFG5] <= acc_pkg::CFG5_DEF;
      end else if (restore_wr) begin
         cfg[acc_pkg::REG_CFG0] <= acc_pkg::CFG0_DEF;
         cfg[acc_pkg::REG_CFG1] <= acc_pkg::CFG1_DEF;
         cfg[acc_pkg::REG_CFG2] <= acc_pkg::CFG2_DEF;
         cfg[acc_pkg::REG_CFG3] <= acc_pkg::CFG3_DEF;
         cfg[acc_pkg::REG_CFG4] <= acc_pkg::CFG4_DEF;
         cfg[acc_pkg::REG_CFG5] <= acc_pkg::CFG5_DEF;
      end else if (wr_en) begin
         unique case (idx)
            acc_pkg::REG_CFG0: cfg[idx] <= wb_dat_i[7:0] & acc_pkg::CFG0_WMASK;
            acc_pkg::REG_CFG1: cfg[idx] <= wb_dat_i[7:0];
            acc_pkg::REG_CFG2: cfg[idx] <= wb_dat_i[7:0];
            acc_pkg::REG_CFG3: cfg[idx] <= wb_dat_i[7:0];
            acc_pkg::REG_CFG4: cfg[idx] <= wb_dat_i[7:0] & acc_pkg::CFG4_WMASK;
            acc_pkg::REG_CFG5: cfg[idx] <= wb_dat_i[7:0] & acc_pkg::CFG5_WMASK;
            default: ;
         endcase
      end
   end

   acc_pkg::acc_cfg0_s c0;
   acc_pkg::acc_cfg1_s c1;
   acc_pkg::acc_cfg2_s c2;
   acc_pkg::acc_cfg3_s c3;
   acc_pkg::acc_cfg4_s c4;
   acc_pkg::acc_cfg5_s c5;

   assign c0 = acc_pkg::acc_cfg0_s'(cfg[acc_pkg::REG_CFG0]);
   assign c1 = acc_pkg::acc_cfg1_s'(cfg[acc_pkg::REG_CFG1]);
   assign c2 = acc_pkg::acc_cfg2_s'(cfg[acc_pkg::REG_CFG2]);
   assign c3 = acc_pkg::acc_cfg3_s'(cfg[acc_pkg::REG_CFG3]);
   assign c4 = acc_pkg::acc_cfg4_s'(cfg[acc_pkg::REG_CFG4]);
   assign c5 = acc_pkg::acc_cfg5_s'(cfg[acc_pkg::REG_CFG5]);

   // ***********************************************
   // analog front end controls
   // ***********************************************
   logic [2:0] pos_input;
   logic [2:0] neg_input;
   logic inputs_connected;

   acc_mux_decode u_mux (
      .input_sel(c5.input_sel),
      .pos_input(pos_input),
      .neg_input(neg_input),
      .connected(inputs_connected)
   );

   always_comb begin
      analog.converter_bias_scale = c1.converter_bias_scale;
      analog.gain_stage_bias_scale = c1.gain_stage_bias_scale;
      analog.modulator_enable = c1.enable[0];
      analog.stage_enable = c1.enable[3:1];
      analog.stage_bypass = ~c1.enable[3:1];
      analog.first_stage_gain = c3.first_stage_gain;
      analog.second_stage_gain = c2.second_stage_gain;
      analog.third_stage_gain = c3.third_stage_gain;
      analog.second_stage_offset = c2.second_stage_offset;
      analog.third_stage_offset = c4.third_stage_offset;
      analog.pos_input = pos_input;
      analog.neg_input = neg_input;
      analog.inputs_connected = inputs_connected;
      analog.ref_select = c5.ref_select;
   end

   // ***********************************************
   // conversion sequencer
   // ***********************************************
   acc_pkg::acc_state_e state;
   logic pending;
   logic launch;
   logic elem_done;
   logic [10:0] period_cnt;
   logic [2:0] elconv_cnt;
   logic [10:0] osr_last;
   logic [2:0] nel_last;
   logic [11:0] fs_period;

   assign fs_period = acc_pkg::FS_BASE_CYC << (acc_pkg::FS_SEL_MAX - c2.sample_freq_sel);
   assign osr_last = acc_pkg::OSR_BASE << c0.oversample_ratio_sel;
   assign nel_last = 3'((acc_pkg::NEL_ONE << c0.conversion_count_sel) - acc_pkg::NEL_ONE);
   assign elem_done = state == acc_pkg::ACC_RUN && sample_tick && period_cnt == osr_last;
   assign conv_done = elem_done && elconv_cnt == nel_last;
   assign launch = !restore_wr && ((state == acc_pkg::ACC_IDLE && pending)
      || (conv_done && (pending || c0.continuous)));
   assign busy = state == acc_pkg::ACC_RUN;

   acc_fs_divider u_div (
      .clk(clk),
      .rst_n(rst_n_sync),
      .restart(launch || restore_wr),
      .period(fs_period),
      .tick(sample_tick)
   );

   always_ff @(posedge clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         pending <= 1'b0;
      end else begin
         pending <= start_wr || cont_wr || (pending && !launch);
      end
   end

   always_ff @(posedge clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         state <= acc_pkg::ACC_IDLE;
      end else if (restore_wr || launch) begin
         state <= acc_pkg::ACC_RUN;
      end else if (conv_done) begin
         state <= acc_pkg::ACC_IDLE;
      end
   end

   always_ff @(posedge clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         period_cnt <= 11'h000;
      end else if (restore_wr || launch || elem_done) begin
         period_cnt <= 11'h000;
      end else if (busy && sample_tick) begin
         period_cnt <= period_cnt + 11'h001;
      end
   end

   always_ff @(posedge clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         elconv_cnt <= 3'h0;
         chop_polarity <= 1'b0;
      end else if (restore_wr || launch) begin
         elconv_cnt <= 3'h0;
         chop_polarity <= 1'b0;
      end else if (elem_done) begin
         elconv_cnt <= elconv_cnt + 3'h1;
         chop_polarity <= !chop_polarity;
      end
   end

   // ***********************************************
   // checks
   // ***********************************************
   logic [11:0] tick_gap;
   logic gap_valid;

   always_ff @(posedge clk or negedge rst_n_sync) begin
      if (!rst_n_sync) begin
         tick_gap <= 12'h000;
         gap_valid <= 1'b0;
      end else if (launch || restore_wr || wr_en) begin
         tick_gap <= 12'h000;
         gap_valid <= 1'b0;
      end else if (sample_tick) begin
         tick_gap <= 12'h000;
         gap_valid <= 1'b1;
      end else begin
         tick_gap <= tick_gap + 12'h001;
      end
   end

   start_read_zero_a: assert property (@(posedge clk) disable iff (!rst_n_sync)
      wb_ack_o && !wb_we_i && idx == acc_pkg::REG_CFG0 |-> !wb_dat_o[7])
      else $error("start bit read back as one");
   reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_n_sync)
      wb_ack_o && !wb_we_i && idx == acc_pkg::REG_CFG4 |-> !wb_dat_o[7])
      else $error("reserved bit read back as one");
   restore_restart_a: assert property (@(posedge clk) disable iff (!rst_n_sync)
      restore_wr |=> busy && period_cnt == 11'h000 && cfg[acc_pkg::REG_CFG2] == 8'hC0
      && analog.stage_enable == 3'h0)
      else $error("restore did not reload and restart");
   cont_chain_a: assert property (@(posedge clk) disable iff (!rst_n_sync)
      conv_done && c0.continuous && !restore_wr |=> busy && elconv_cnt == 3'h0)
      else $error("continuous mode did not restart");
   chop_toggle_a: assert property (@(posedge clk) disable iff (!rst_n_sync)
      elem_done && !conv_done && !restore_wr |=> chop_polarity != $past(chop_polarity))
      else $error("chop polarity did not toggle");
   osr_span_a: assert property (@(posedge clk) disable iff (!rst_n_sync)
      elem_done |-> period_cnt == (11'h008 << c0.oversample_ratio_sel))
      else $error("elementary conversion length wrong");
   tick_period_a: assert property (@(posedge clk) disable iff (!rst_n_sync)
      sample_tick && gap_valid && !$past(wr_en) |-> tick_gap == fs_period - 12'h001)
      else $error("sampling period wrong");
   diff_open_a: assert property (@(posedge clk) disable iff (!rst_n_sync)
      !c5.input_sel[4] && c5.input_sel[1:0] == 2'h3 |-> !analog.inputs_connected)
      else $error("open differential code connected");
   single_shot_a: assert property (@(posedge clk) disable iff (!rst_n_sync)
      start_wr && !busy && !restore_wr |-> ##[1:2] busy)
      else $error("start did not begin a conversion");
   busy_end_a: assert property (@(posedge clk) disable iff (!rst_n_sync)
      conv_done && !launch && !restore_wr |=> !busy)
      else $error("busy stayed high after conversion");

endmodule : acc_chain_ctrl
`default_nettype wire

// [tb/acc_host_model.sv]
// host model: classic wishbone master doing single byte register accesses
// assumes xfer is entered just after a rising edge; it waits for ack with no cycle limit
`timescale 1ns/10ps
`default_nettype none
module acc_host_model (
   input wire logic clk,
   output logic cyc,
   output logic stb,
   output logic we,
   output logic [4:0] adr,
   output logic [31:0] dat_w,
   output logic [3:0] sel,
   input wire logic ack,
   input wire logic [31:0] dat_r
);
   // ***********************************************
   // bus cycle
   // ***********************************************
   initial begin
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 5'h00;
      dat_w = 32'h00000000;
      sel = 4'hF;
   end
   task automatic xfer(input logic w, input logic [2:0] idx, input logic [7:0] d,
                       output logic [31:0] q);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'h0};
      dat_w <= {24'h000000, d};
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      q = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk);
   endtask : xfer
endmodule : acc_host_model
`default_nettype wire

// [tb/acc_chain_ctrl_tb.sv]
// testbench of the acquisition chain control: registers, mux decode, sequencing
// assumes acc_host_model as register bus master and a 200 MHz clock
`timescale 1ns/10ps
`default_nettype none
module acc_chain_ctrl_tb;
   // ***********************************************
   // harness
   // ***********************************************
   logic clk;
   logic nrst;
   logic cyc, stb, we, ack, sample_tick, chop_polarity, conv_done, busy;
   logic [4:0] adr;
   logic [31:0] dat_w, dat_r;
   logic [3:0] sel;
   acc_pkg::acc_analog_s analog;
   int errors = 0;
   int num_checks = 0;
   acc_host_model u_host (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
      .dat_w(dat_w), .sel(sel), .ack(ack), .dat_r(dat_r));
   acc_chain_ctrl u_dut (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat_w), .wb_sel_i(sel), .wb_dat_o(dat_r),
      .wb_ack_o(ack), .analog(analog), .sample_tick(sample_tick),
      .chop_polarity(chop_polarity), .conv_done(conv_done), .busy(busy));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [2:0] i, input logic [7:0] d);
      logic [31:0] q;
      u_host.xfer(1'b1, i, d, q);
   endtask : wr
   task automatic rd_chk(input logic [2:0] i, input logic [7:0] e);
      logic [31:0] q;
      u_host.xfer(1'b0, i, 8'h00, q);
      chk(q, {24'h000000, e});
   endtask : rd_chk
   task automatic count_ticks(output int n, output logic ch);
      n = 0;
      ch = 1'bx;
      for (int c = 0; c < 40000; c++) begin
         @(posedge clk);
         if (sample_tick === 1'b1) n++;
         if (sample_tick === 1'b1 && n == 10) ch = chop_polarity;
         if (conv_done === 1'b1) break;
      end
   endtask : count_ticks
   task automatic tick_gap(output int g);
      g = 0;
      @(posedge clk);
      for (int c = 0; c < 8000 && sample_tick !== 1'b1; c++) @(posedge clk);
      do begin
         @(posedge clk);
         g++;
      end while (sample_tick !== 1'b1 && g < 8000);
   endtask : tick_gap
   // ***********************************************
   // scenarios
   // ***********************************************
   task automatic test_defaults;
      rd_chk(3'h0, 8'h28);
      rd_chk(3'h1, 8'hF0);
      rd_chk(3'h2, 8'hC0);
      rd_chk(3'h3, 8'h00);
      rd_chk(3'h5, 8'h00);
      rd_chk(3'h6, 8'h00);
      $display("test defaults done");
   endtask : test_defaults
   task automatic test_fields;
      wr(3'h1, 8'h6B);
      chk(analog.converter_bias_scale, 2'h1);
      chk(analog.gain_stage_bias_scale, 2'h2);
      chk({analog.modulator_enable, analog.stage_enable}, 4'hD);
      chk(analog.stage_bypass, 3'h2);
      wr(3'h2, 8'h5A);
      rd_chk(3'h2, 8'h5A);
      chk(analog.second_stage_gain, 2'h1);
      chk(analog.second_stage_offset, 4'hA);
      wr(3'h3, 8'hA5);
      chk({analog.first_stage_gain, analog.third_stage_gain}, 8'hA5);
      wr(3'h4, 8'hFF);
      rd_chk(3'h4, 8'h7F);
      chk(analog.third_stage_offset, 7'h7F);
      wr(3'h5, 8'h81);
      rd_chk(3'h5, 8'h01);
      chk(analog.ref_select, 1'b1);
      $display("test fields done");
   endtask : test_fields
   task automatic test_mux;
      logic [11:0] tab[8] = '{12'h011, 12'h0B5, 12'h54B, 12'h180, 12'h9B1, 12'hD87,
                              12'hB00, 12'h580};
      foreach (tab[k]) begin
         wr(3'h5, {1'b0, tab[k][11:7], 1'b0});
         chk(analog.inputs_connected, tab[k][0]);
         if (tab[k][0]) chk({analog.pos_input, analog.neg_input}, tab[k][6:1]);
      end
      chk(analog.ref_select, 1'b0);
      $display("test mux done");
   endtask : test_mux
   task automatic test_conv;
      int n;
      logic ch;
      wr(3'h2, 8'hC0);
      wr(3'h0, 8'hA0);
      rd_chk(3'h0, 8'h20);
      rd_chk(3'h5, 8'h96);
      count_ticks(n, ch);
      chk(n, 18);
      chk(ch, 1'b1);
      repeat (2) @(posedge clk);
      chk(busy, 1'b0);
      $display("test conversion done");
   endtask : test_conv
   task automatic test_chain(input logic [7:0] first, input logic [7:0] second);
      int n;
      logic ch;
      wr(3'h0, first);
      if (!first[1]) wr(3'h0, second);
      count_ticks(n, ch);
      chk(n, 18);
      @(posedge clk);
      chk(busy, 1'b1);
      if (first[1]) wr(3'h0, second);
      count_ticks(n, ch);
      chk(n, 18);
      repeat (2) @(posedge clk);
      chk(busy, 1'b0);
      $display("test chaining done");
   endtask : test_chain
   task automatic test_rate_restore;
      int g;
      int n;
      logic ch;
      for (int fs = 3; fs >= 0; fs--) begin
         wr(3'h2, {fs[1:0], 6'h00});
         wr(3'h0, 8'h80);
         tick_gap(g);
         chk(g, 400 << (3 - fs));
         if (fs != 0) count_ticks(n, ch);
      end
      wr(3'h5, 8'h40);
      chk(busy, 1'b1);
      rd_chk(3'h1, 8'hF0);
      rd_chk(3'h0, 8'h28);
      rd_chk(3'h5, 8'h80);
      tick_gap(g);
      chk(g, 400);
      $display("test rate and restore done");
   endtask : test_rate_restore
   // ***********************************************
   // sequence and verdict
   // ***********************************************
   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : finish_test
   initial begin
      repeat (90000) @(posedge clk);
      errors++;
      finish_test();
   end
   initial begin
      nrst = 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      repeat (4) @(posedge clk);
      test_defaults();
      test_fields();
      test_mux();
      test_conv();
      test_chain(8'hA0, 8'hA0);
      test_chain(8'h22, 8'h20);
      test_rate_restore();
      finish_test();
   end
endmodule : acc_chain_ctrl_tb
`default_nettype wire
